// File: hw/wwt_params.svh
// Constants for the watch and interval timer: address, reset value, widths and taps.
`ifndef WWT_PARAMS_SVH
`define WWT_PARAMS_SVH

`define WWT_MODE_ADDR 16'hff6f
`define WWT_MODE_RESET 8'h00
`define WWT_ADDR_W 16
`define WWT_DATA_W 8
`define WWT_PRESC_W 11
`define WWT_CNT_W 5
`define WWT_DIV_W 7
`define WWT_DIV_LAST 7'h7f
`define WWT_INTERVAL_BASE 4
`define WWT_LONG_TAP 9
`define WWT_SHORT_TAP_HI 5
`define WWT_SHORT_TAP_LO 4
`define WWT_CNT_FULL 5'h1f
`define WWT_CNT_HALF_MASK 5'h0f

`endif

// File: hw/wwt_pkg.sv
// Types shared by the watch and interval timer.
package wwt_pkg;

  // Field order follows bit order of the mode register, bit 7 first.
  typedef struct packed {
    logic clk_sel;
    logic [2:0] interval_sel;
    logic [1:0] watch_sel;
    logic small_counter_run;
    logic timer_run_enable;
  } wwt_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic byte_wr;
    logic bit_wr;
    logic [2:0] bit_idx;
    logic bit_val;
    logic [7:0] wdata;
    logic rd;
  } wwt_bus_req_t;

  typedef enum logic [1:0] {
    WWT_WP_2P14 = 2'b00,
    WWT_WP_2P13 = 2'b01,
    WWT_WP_2P5 = 2'b10,
    WWT_WP_2P4 = 2'b11
  } wwt_watch_period_t;

endpackage

// File: hw/wwt_top.sv
// Watch and interval timer core with its mode register on the internal bus.
`timescale 1ns/1ps
`include "wwt_params.svh"

module wwt_top
  import wwt_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic sub_clock_in,
  input wire wwt_bus_req_t bus_req,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic watch_period_irq,
  output logic interval_period_irq
);

  // ==========================================================
  // Helpers
  // True when the low w bits of the prescaler are all ones, so the next tick
  // carries into bit w and one period of 2^w count clocks ends.
  function automatic logic low_ones(input logic [`WWT_PRESC_W-1:0] v, input int w);
    logic r;
    r = 1'b1;
    for (int i = 0; i < `WWT_PRESC_W; i++) begin
      if (i < w && !v[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Mode register
  logic [7:0] watch_mode_control;
  logic [7:0] next_watch_mode_control;
  logic [7:0] next_rdata;
  logic next_rdata_valid;
  logic addr_hit;
  wwt_mode_t mode;

  assign mode = wwt_mode_t'(watch_mode_control);
  assign addr_hit = (bus_req.addr == `WWT_MODE_ADDR);

  always_comb begin
    next_watch_mode_control = watch_mode_control;
    if (addr_hit && bus_req.byte_wr) begin
      next_watch_mode_control = bus_req.wdata;
    end else if (addr_hit && bus_req.bit_wr) begin
      next_watch_mode_control[bus_req.bit_idx] = bus_req.bit_val;
    end
    // Unmapped reads answer zero so a stray access never returns stale data.
    next_rdata = (bus_req.rd && addr_hit) ? watch_mode_control : 8'h00;
    next_rdata_valid = bus_req.rd;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      watch_mode_control <= `WWT_MODE_RESET;
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
    end else if (clk_en) begin
      watch_mode_control <= next_watch_mode_control;
      rdata <= next_rdata;
      rdata_valid <= next_rdata_valid;
    end
  end

  // ==========================================================
  // Count clock
  // The subsystem clock is far slower than clock, so its rising edges are
  // found after a two-stage synchroniser; jitter of one cycle is harmless.
  logic sub_sync1;
  logic sub_sync2;
  logic sub_prev;
  logic [`WWT_DIV_W-1:0] div_cnt;
  logic [`WWT_DIV_W-1:0] next_div_cnt;
  logic count_tick;

  always_comb begin
    next_div_cnt = mode.timer_run_enable ? `WWT_DIV_W'(div_cnt + 7'h01) : 7'h00;
    if (mode.clk_sel) begin
      count_tick = sub_sync2 && !sub_prev;
    end else begin
      count_tick = (div_cnt == `WWT_DIV_LAST);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sub_sync1 <= 1'b0;
      sub_sync2 <= 1'b0;
      sub_prev <= 1'b0;
      div_cnt <= 7'h00;
    end else if (clk_en) begin
      sub_sync1 <= sub_clock_in;
      sub_sync2 <= sub_sync1;
      sub_prev <= sub_sync2;
      div_cnt <= next_div_cnt;
    end
  end

  // ==========================================================
  // Prescaler, 5-bit counter and request pulses
  logic [`WWT_PRESC_W-1:0] presc;
  logic [`WWT_PRESC_W-1:0] next_presc;
  logic [`WWT_CNT_W-1:0] small_cnt;
  logic [`WWT_CNT_W-1:0] next_small_cnt;
  logic next_watch_irq;
  logic next_interval_irq;
  logic run_tick;
  logic long_tap;
  logic watch_on;

  assign run_tick = mode.timer_run_enable && count_tick;
  assign long_tap = low_ones(presc, `WWT_LONG_TAP);
  assign watch_on = mode.timer_run_enable && mode.small_counter_run;

  always_comb begin
    next_presc = presc;
    next_small_cnt = small_cnt;
    if (!mode.timer_run_enable) begin
      next_presc = '0;
    end else if (count_tick) begin
      next_presc = `WWT_PRESC_W'(presc + 11'h001);
    end
    // Only the 5-bit counter is cleared here; with timer_run_enable set the prescaler keeps its phase.
    if (!watch_on) begin
      next_small_cnt = '0;
    end else if (count_tick && long_tap) begin
      next_small_cnt = `WWT_CNT_W'(small_cnt + 5'h01);
    end
    next_interval_irq = run_tick &&
      low_ones(presc, `WWT_INTERVAL_BASE + int'(mode.interval_sel));
    next_watch_irq = 1'b0;
    if (watch_on && count_tick) begin
      case (wwt_watch_period_t'(mode.watch_sel))
        WWT_WP_2P14: begin
          next_watch_irq = long_tap && (small_cnt == `WWT_CNT_FULL);
        end
        WWT_WP_2P13: begin
          next_watch_irq = long_tap &&
            ((small_cnt & `WWT_CNT_HALF_MASK) == `WWT_CNT_HALF_MASK);
        end
        WWT_WP_2P5: begin
          next_watch_irq = low_ones(presc, `WWT_SHORT_TAP_HI);
        end
        WWT_WP_2P4: begin
          next_watch_irq = low_ones(presc, `WWT_SHORT_TAP_LO);
        end
        default: begin
          next_watch_irq = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      presc <= '0;
      small_cnt <= '0;
      watch_period_irq <= 1'b0;
      interval_period_irq <= 1'b0;
    end else if (clk_en) begin
      presc <= next_presc;
      small_cnt <= next_small_cnt;
      watch_period_irq <= next_watch_irq;
      interval_period_irq <= next_interval_irq;
    end
  end

endmodule // wwt_top

// File: tb/wwt_properties.sv
// Port-level checks for the watch and interval timer.
`timescale 1ns/1ps
module wwt_properties
  import wwt_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic sub_clock_in,
  input wire wwt_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid,
  input wire logic watch_period_irq,
  input wire logic interval_period_irq
);
  // ==========================================================
  // Shadow mode register, rebuilt from the bus so no body signal is needed.
  logic [7:0] m;
  logic hit;
  assign hit = clk_en && bus_req.addr == 16'hff6f;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) m <= 8'h00;
    else if (hit && bus_req.byte_wr) m <= bus_req.wdata;
    else if (hit && bus_req.bit_wr) m[bus_req.bit_idx] <= bus_req.bit_val;
  end
  // ==========================================================
  // Assertions.
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_RESET: assert property ($rose(nrst) |-> rdata == 8'h00 && !rdata_valid)
    else $error("outputs not clear after reset");
  AST_RD_VALID: assert property (clk_en && bus_req.rd |=> rdata_valid)
    else $error("read not answered");
  AST_RD_DATA: assert property (hit && bus_req.rd |=> rdata == $past(m))
    else $error("mode readback wrong");
  AST_RD_UNMAP: assert property (bus_req.rd && !hit && clk_en |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_STOP_IV: assert property ((clk_en && !m[0]) [*2] |=> !interval_period_irq)
    else $error("interval pulse while stopped");
  AST_STOP_WT: assert property ((clk_en && m[1:0] != 2'b11) [*2] |=> !watch_period_irq)
    else $error("watch pulse while counter stopped");
  AST_IV_PULSE: assert property (interval_period_irq && clk_en |=> !interval_period_irq)
    else $error("interval pulse too long");
  AST_WT_PULSE: assert property (watch_period_irq && clk_en |=> !watch_period_irq)
    else $error("watch pulse too long");
  COV_WT: cover property (watch_period_irq);
  COV_IV: cover property (interval_period_irq);
  COV_BIT: cover property (hit && bus_req.bit_wr);
endmodule // wwt_properties

bind wwt_top wwt_properties u_chk (.clock(clock), .nrst(nrst), .clk_en(clk_en),
  .sub_clock_in(sub_clock_in), .bus_req(bus_req), .rdata(rdata), .rdata_valid(rdata_valid),
  .watch_period_irq(watch_period_irq), .interval_period_irq(interval_period_irq));

// File: tb/watch_and_interval_timer_tb_top.sv
// Self-checking bench for the watch and interval timer.
`timescale 1ns/1ps
module watch_and_interval_timer_tb_top
  import wwt_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic sub_clock_in = 1'b0;
  wwt_bus_req_t bus_req = '0;
  logic [7:0] rdata;
  logic rdata_valid, watch_period_irq, interval_period_irq;
  int n_errors = 0;
  int n_checks = 0;
  wwt_top dut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .sub_clock_in(sub_clock_in),
    .bus_req(bus_req), .rdata(rdata), .rdata_valid(rdata_valid),
    .watch_period_irq(watch_period_irq), .interval_period_irq(interval_period_irq));
  initial forever #2 clock = ~clock;
  // Subsystem clock of eight system cycles, so one count tick every 8 cycles.
  always begin
    repeat (4) @(posedge clock);
    sub_clock_in <= ~sub_clock_in;
  end
  // ==========================================================
  // Helpers.
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic put(wwt_bus_req_t r);
    @(posedge clock);
    bus_req <= r;
    @(posedge clock);
    bus_req <= '0;
    @(negedge clock);
  endtask
  task automatic wr(logic [7:0] d);
    put('{16'hff6f, 1'b1, 1'b0, 3'h0, 1'b0, d, 1'b0});
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    put('{a, 1'b0, 1'b0, 3'h0, 1'b0, 8'h00, 1'b1});
    chk("rdata_valid", rdata_valid, 1'b1);
    chk("rdata", rdata, e);
  endtask
  // Measures the spacing of two pulses, so the tick phase does not matter.
  task automatic per(ref logic s, input int e);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 3 * e) begin
      @(negedge clock);
      n++;
    end
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (s !== 1'b1 && n < 3 * e);
    chk("period", n, e);
  endtask
  // ==========================================================
  // Scenarios.
  task automatic s_regs;
    rd(16'hff6f, 8'h00);
    rd(16'hff6e, 8'h00);
    wr(8'ha4);
    put('{16'hff6f, 1'b0, 1'b1, 3'h1, 1'b1, 8'h00, 1'b0});
    put('{16'hff6f, 1'b0, 1'b1, 3'h7, 1'b0, 8'h00, 1'b0});
    rd(16'hff6f, 8'h26);
    @(posedge clock);
    clk_en <= 1'b0;
    wr(8'hff);
    @(posedge clock);
    clk_en <= 1'b1;
    rd(16'hff6f, 8'h26);
    wr(8'h00);
  endtask
  task automatic s_interval;
    for (int n = 0; n < 8; n++) begin
      wr({1'b1, n[2:0], 4'h1});
      per(interval_period_irq, 8 << (4 + n));
      wr(8'h00);
    end
    wr(8'h01);
    per(interval_period_irq, 2048);
    // Stop before the next scenario changes the clock select.
    wr(8'h00);
  endtask
  task automatic s_watch;
    wr(8'h8f);
    per(watch_period_irq, 128);
    per(interval_period_irq, 128);
    wr(8'h8b);
    per(watch_period_irq, 256);
    wr(8'h00);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    s_regs;
    s_interval;
    s_watch;
    wrap_up;
  end
  // About 70000 cycles are needed; the limit stops a hang below 100000 cycles.
  initial begin
    #380000;
    n_errors++;
    wrap_up;
  end
endmodule // watch_and_interval_timer_tb_top
